// >>> verilog/lpd_defines.svh
// constants for the lcd and pwm command decoder
`ifndef LPD_DEFINES_SVH
`define LPD_DEFINES_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define LPD_OP_STATIC_LOW     5'h0C
`define LPD_OP_STATIC_HIGH    5'h0D
`define LPD_OP_LED_POINTER    5'h0E
`define LPD_OP_LCD_POINTER    2'h2
`define LPD_OP_LED_DIVIDER    4'h4
`define LPD_SEL_RAM           2'h1
`define LPD_SEL_DUTY          2'h2

// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define LPD_LCD_MAX_MUX8      6'h27
`define LPD_LCD_MAX_MUX6      6'h29
`define LPD_LCD_MAX_MUX4      6'h2B
`define LPD_LED_MAX           3'h5
`define LPD_LCD_DIV_RESET     5'h0E
`define LPD_LED_DIV_RESET     4'h7
`define LPD_FIFO_DEPTH        8

`endif

// >>> verilog/lpd_pkg.sv
// types shared by the lcd and pwm command decoder
package lpd_pkg;

	// ----------------------------------------
	// stream and mode types
	// ----------------------------------------
	typedef struct packed {
		logic       isData;
		logic [1:0] targetSelect;
		logic [7:0] value;
	} lpd_stream_type;

	typedef enum logic [1:0] {
		LPD_AUX_OFF    = 2'h0,
		LPD_AUX_STATIC = 2'h1,
		LPD_AUX_PWM    = 2'h2,
		LPD_AUX_SPARE  = 2'h3
	} lpd_aux_mode_type;

	typedef enum logic [1:0] {
		LPD_MUX_8 = 2'h0,
		LPD_MUX_6 = 2'h1,
		LPD_MUX_4 = 2'h2,
		LPD_MUX_X = 2'h3
	} lpd_mux_type;

	typedef struct packed {
		logic                  displayOn;
		logic                  backplaneSwap;
		logic                  drivePolaritySel;
		logic                  lowPowerSel;
		logic                  clockRateSel;
		logic                  clockOutOn;
		logic                  clockSourceSel;
		logic                  dutyPolaritySel;
		lpd_aux_mode_type [5:0] auxOutputMode;
		lpd_mux_type           muxMode;
		logic [1:0]            biasMode;
		logic [4:0]            lcdFrameDividerCode;
		logic [3:0]            ledFrameDividerCode;
	} lpd_config_type;

endpackage : lpd_pkg

// >>> verilog/lpd_fifo.sv
// byte fifo between the framing layer and the decoder
`timescale 1ns/1ps
module lpd_fifo #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output      logic             inReady,
	output      logic             outValid,
	output      logic [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || WIDTH < 1)
		begin : gBadSize
			$error("lpd_fifo needs depth of two or more");
		end
	endgenerate

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    writeIndex;
	logic [AW-1:0]    readIndex;
	logic [AW:0]      fill;
	logic [AW:0]      next_fill;
	logic             push;
	logic             pop;

	// depth need not be a power of two, so wrap explicitly
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] idx);
		bump = (idx == AW'(DEPTH - 1)) ? '0 : idx + 1'b1;
	endfunction : bump

	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;
	assign outValid = (fill != '0);
	assign outData  = store[readIndex];

	always_comb
	begin
		next_fill = fill;
		if (push && !pop)
			next_fill = fill + 1'b1;
		else if (pop && !push)
			next_fill = fill - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (push)
			store[writeIndex] <= inData;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			writeIndex <= '0;
			readIndex  <= '0;
			fill       <= '0;
			inReady    <= 1'b1;
		end
		else
		begin
			if (push)
				writeIndex <= bump(writeIndex);
			if (pop)
				readIndex <= bump(readIndex);
			fill    <= next_fill;
			// registered so the source sees a clean flop
			inReady <= (next_fill < (AW+1)'(DEPTH));
		end
	end
endmodule : lpd_fifo

// >>> verilog/lpd_decoder.sv
// command and data byte decoder for display ram, duty values and aux pins
`timescale 1ns/1ps
`include "lpd_defines.svh"
module lpd_decoder #(
	parameter int FIFO_DEPTH = `LPD_FIFO_DEPTH
) (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic                   byteValid,
	input  wire lpd_pkg::lpd_stream_type byteIn,
	output      logic                   byteReady,
	input  wire logic                   configLoad,
	input  wire lpd_pkg::lpd_config_type configIn,
	output      lpd_pkg::lpd_config_type configOut,
	input  wire logic                   ramReady,
	output      logic                   ramWriteStrobe,
	output      logic [5:0]             ramWriteAddr,
	output      logic [7:0]             ramWriteData,
	output      logic [41:0]            dutyValues,
	input  wire logic [5:0]             pwmWave,
	input  wire logic                   oscTick,
	output      logic [5:0]             auxPin,
	output      logic [5:0]             auxPinOe,
	output      logic                   clockIoPinOut,
	output      logic                   clockIoPinOe,
	output      logic                   displayEnable,
	output      logic [5:0]             lcdRamPointer,
	output      logic                   lcdPointerValid,
	output      logic [2:0]             ledChannelPointer,
	output      logic                   ledPointerValid,
	output      logic [5:0]             staticLevel
);
	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	generate
		if (FIFO_DEPTH < 2)
		begin : gBadDepth
			$error("lpd_decoder needs a fifo of two or more words");
		end
	endgenerate

	localparam int SW = $bits(lpd_pkg::lpd_stream_type);

	// ----------------------------------------
	// input fifo
	// ----------------------------------------
	logic                    headValid;
	logic                    headReady;
	logic [SW-1:0]           headBits;
	lpd_pkg::lpd_stream_type head;

	lpd_fifo #(
		.WIDTH (SW),
		.DEPTH (FIFO_DEPTH)
	) uFifo (
		.clk      (clk),
		.reset    (reset),
		.inValid  (byteValid),
		.inData   (byteIn),
		.inReady  (byteReady),
		.outValid (headValid),
		.outData  (headBits),
		.outReady (headReady)
	);

	assign head = lpd_pkg::lpd_stream_type'(headBits);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// ram depth depends on the mux mode; an unused code is treated as the four-way mux, the deepest ram
	function automatic logic [5:0] lcd_max(input lpd_pkg::lpd_mux_type mux);
		case (mux)
			lpd_pkg::LPD_MUX_8: lcd_max = `LPD_LCD_MAX_MUX8;
			lpd_pkg::LPD_MUX_6: lcd_max = `LPD_LCD_MAX_MUX6;
			lpd_pkg::LPD_MUX_4: lcd_max = `LPD_LCD_MAX_MUX4;
			default:            lcd_max = `LPD_LCD_MAX_MUX4;
		endcase
	endfunction : lcd_max

	function automatic logic aux_drives(input lpd_pkg::lpd_aux_mode_type mode);
		aux_drives = (mode == lpd_pkg::LPD_AUX_STATIC) || (mode == lpd_pkg::LPD_AUX_PWM);
	endfunction : aux_drives

	// ----------------------------------------
	// head decode
	// ----------------------------------------
	logic       isCommand;
	logic       cmdStaticLow;
	logic       cmdStaticHigh;
	logic       cmdLcdPointer;
	logic       cmdLedPointer;
	logic       cmdLedDivider;
	logic       wantRam;
	logic       doRam;
	logic       doDuty;
	logic       take;
	logic [5:0] lcdLimit;

	assign lcdLimit      = lcd_max(configOut.muxMode);
	assign isCommand     = !head.isData;
	assign cmdStaticLow  = isCommand && (head.value[7:3] == `LPD_OP_STATIC_LOW);
	assign cmdStaticHigh = isCommand && (head.value[7:3] == `LPD_OP_STATIC_HIGH);
	assign cmdLedPointer = isCommand && (head.value[7:3] == `LPD_OP_LED_POINTER);
	assign cmdLcdPointer = isCommand && (head.value[7:6] == `LPD_OP_LCD_POINTER);
	assign cmdLedDivider = isCommand && (head.value[7:4] == `LPD_OP_LED_DIVIDER);

	// ram writes wait for the ram port; everything else goes in one cycle
	assign wantRam   = head.isData && (head.targetSelect == `LPD_SEL_RAM) && lcdPointerValid;
	assign doRam     = headValid && wantRam && ramReady;
	assign doDuty    = headValid && head.isData && (head.targetSelect == `LPD_SEL_DUTY)
		&& ledPointerValid;
	assign headReady = !wantRam || ramReady;
	assign take      = headValid && headReady;

	// ----------------------------------------
	// configuration fields
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			configOut                     <= '0;
			configOut.muxMode             <= lpd_pkg::LPD_MUX_8;
			configOut.lcdFrameDividerCode <= `LPD_LCD_DIV_RESET;
			configOut.ledFrameDividerCode <= `LPD_LED_DIV_RESET;
		end
		else if (configLoad)
		begin
			configOut <= configIn;
		end
		else if (take && cmdLedDivider)
		begin
			configOut.ledFrameDividerCode <= head.value[3:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			displayEnable <= 1'b0;
		else
			displayEnable <= configLoad ? configIn.displayOn : configOut.displayOn;
	end

	// ----------------------------------------
	// static levels
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			staticLevel <= '0;
		end
		else if (take)
		begin
			if (cmdStaticLow)
				staticLevel[2:0] <= head.value[2:0];
			if (cmdStaticHigh)
				staticLevel[5:3] <= head.value[2:0];
		end
	end

	// ----------------------------------------
	// display ram pointer
	// ----------------------------------------
	// an out-of-range load keeps the old value but blocks writes
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			lcdRamPointer   <= '0;
			lcdPointerValid <= 1'b1;
		end
		else if (take && cmdLcdPointer)
		begin
			if (head.value[5:0] <= lcdLimit)
			begin
				lcdRamPointer   <= head.value[5:0];
				lcdPointerValid <= 1'b1;
			end
			else
			begin
				lcdPointerValid <= 1'b0;
			end
		end
		else if (doRam)
		begin
			lcdRamPointer <= lcdRamPointer + 1'b1;
			// running past the end blocks writes until a fresh load
			if (lcdRamPointer >= lcdLimit)
				lcdPointerValid <= 1'b0;
		end
		else if (lcdRamPointer > lcdLimit)
		begin
			// a later mux change can shrink the ram under the pointer
			lcdPointerValid <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ramWriteStrobe <= 1'b0;
			ramWriteAddr   <= '0;
			ramWriteData   <= '0;
		end
		else
		begin
			ramWriteStrobe <= doRam;
			if (doRam)
			begin
				ramWriteAddr <= lcdRamPointer;
				ramWriteData <= head.value;
			end
		end
	end

	// ----------------------------------------
	// pwm channel pointer and duty values
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ledChannelPointer <= '0;
			ledPointerValid   <= 1'b1;
		end
		else if (take && cmdLedPointer)
		begin
			if (head.value[2:0] <= `LPD_LED_MAX)
			begin
				ledChannelPointer <= head.value[2:0];
				ledPointerValid   <= 1'b1;
			end
			else
			begin
				ledPointerValid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			dutyValues <= '0;
		end
		else if (doDuty)
		begin
			// bit 7 of the byte is dropped, only seven bits are held
			dutyValues[ledChannelPointer * 7 +: 7] <= head.value[6:0];
		end
	end

	// ----------------------------------------
	// aux pins
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			auxPin   <= '0;
			auxPinOe <= '0;
		end
		else
		begin
			for (int i = 0; i < 6; i++)
			begin
				auxPinOe[i] <= aux_drives(configOut.auxOutputMode[i]);
				case (configOut.auxOutputMode[i])
					lpd_pkg::LPD_AUX_STATIC: auxPin[i] <= staticLevel[i];
					lpd_pkg::LPD_AUX_PWM:    auxPin[i] <= pwmWave[i];
					default:                 auxPin[i] <= 1'b0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// clock pin
	// ----------------------------------------
	// only the internal oscillator can be sent out; an external clock keeps the pin as input
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			clockIoPinOe  <= 1'b0;
			clockIoPinOut <= 1'b0;
		end
		else
		begin
			clockIoPinOe  <= configOut.clockOutOn && !configOut.clockSourceSel;
			clockIoPinOut <= oscTick && configOut.clockOutOn && !configOut.clockSourceSel;
		end
	end
endmodule : lpd_decoder

// >>> verilog/lpd_decoder_note_end.sv
// spare file, holds no logic of the decoder

// >>> tb/lpd_decoder_asserts.sv
// assertion checker for the lcd and pwm command decoder
`timescale 1ns/1ps
module lpd_decoder_asserts (
	input wire logic                    clk,
	input wire logic                    reset,
	input wire lpd_pkg::lpd_config_type configOut,
	input wire logic                    ramWriteStrobe,
	input wire logic [5:0]              ramWriteAddr,
	input wire logic [41:0]             dutyValues,
	input wire logic [5:0]              auxPin,
	input wire logic [5:0]              auxPinOe,
	input wire logic                    clockIoPinOe,
	input wire logic                    clockIoPinOut,
	input wire logic                    oscTick,
	input wire logic [5:0]              pwmWave,
	input wire logic [5:0]              lcdRamPointer,
	input wire logic                    lcdPointerValid,
	input wire logic [2:0]              ledChannelPointer,
	input wire logic                    ledPointerValid,
	input wire logic [5:0]              staticLevel
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_released;
		$fell(reset);
	endsequence
	chk_reset_state:
	assert property (s_released |-> lcdRamPointer == 6'h00 && ledChannelPointer == 3'h0
		&& dutyValues == '0 && staticLevel == 6'h00 && auxPinOe == 6'h00
		&& configOut == {24'h00_0000, 5'h0E, 4'h7}) else $error("reset state wrong");
	chk_ptr_advance:
	assert property (ramWriteStrobe |-> lcdRamPointer == ramWriteAddr + 6'h01)
		else $error("pointer not advanced");
	chk_write_guard:
	assert property (ramWriteStrobe |-> $past(lcdPointerValid)) else $error("write with bad pointer");
	chk_duty_guard:
	assert property ($changed(dutyValues) |-> $past(ledPointerValid)) else $error("duty with bad pointer");
	chk_led_limit:
	assert property (ledPointerValid |-> ledChannelPointer <= 3'h5) else $error("pwm pointer range");
	chk_clock_pin:
	assert property (!configOut.clockOutOn [*2] |-> !clockIoPinOe) else $error("clock pin driven");
	chk_clock_out:
	assert property (1'b1 |-> clockIoPinOe == ($past(configOut.clockOutOn) && !$past(configOut.clockSourceSel))
		&& clockIoPinOut == ($past(oscTick) && $past(configOut.clockOutOn) && !$past(configOut.clockSourceSel)))
		else $error("clock pin output wrong");
	for (genvar i = 0; i < 6; i++)
	begin : g_pin
		chk_aux_static:
		assert property ($past(configOut.auxOutputMode[i]) == lpd_pkg::LPD_AUX_STATIC
			|-> auxPinOe[i] && auxPin[i] == $past(staticLevel[i])) else $error("static pin wrong");
		chk_aux_off:
		assert property ($past(configOut.auxOutputMode[i]) inside {lpd_pkg::LPD_AUX_OFF, lpd_pkg::LPD_AUX_SPARE}
			|-> !auxPinOe[i] && !auxPin[i]) else $error("disabled pin driven");
		chk_aux_pwm:
		assert property ($past(configOut.auxOutputMode[i]) == lpd_pkg::LPD_AUX_PWM
			|-> auxPinOe[i] && auxPin[i] == $past(pwmWave[i])) else $error("pwm pin wrong");
	end
endmodule : lpd_decoder_asserts

bind lpd_decoder lpd_decoder_asserts lpd_decoder_asserts_inst (.clk, .reset, .configOut, .ramWriteStrobe,
	.ramWriteAddr, .dutyValues, .auxPin, .auxPinOe, .clockIoPinOe, .clockIoPinOut, .oscTick, .pwmWave,
	.lcdRamPointer, .lcdPointerValid,
	.ledChannelPointer, .ledPointerValid, .staticLevel);

// >>> tb/lpd_host_model.sv
// host model offering command and data bytes in order
`timescale 1ns/1ps
module lpd_host_model (
	input wire logic                     clk,
	input wire logic                     reset,
	input wire logic                     slow,
	input wire logic                     byteReady,
	output     logic                     byteValid,
	output     lpd_pkg::lpd_stream_type  byteIn
);
	lpd_pkg::lpd_stream_type q[$];
	int                      seed = 32'h5242d6ad;
	// idle bus shows a changing pattern, not the last byte
	always @(posedge clk)
	begin
		if (reset)
		begin
			byteValid <= 1'b0;
			byteIn <= '0;
		end
		else if (!byteValid || byteReady)
		begin
			if (q.size() != 0 && !(slow && $random(seed) % 2))
			begin
				byteValid <= 1'b1;
				byteIn <= q.pop_front();
			end
			else
			begin
				byteValid <= 1'b0;
				byteIn <= ~byteIn;
			end
		end
	end
endmodule : lpd_host_model

// >>> tb/lpd_decoder_tb.sv
// self-checking bench for the lcd and pwm command decoder
`timescale 1ns/1ps
module lpd_decoder_tb;
	lpd_pkg::lpd_stream_type byteIn;
	lpd_pkg::lpd_config_type configIn, configOut;
	lpd_pkg::lpd_mux_type    mux;
	logic        clk, reset, byteValid, byteReady, configLoad, ramReady, ramWriteStrobe, oscTick, slow;
	logic        clockIoPinOut, clockIoPinOe, displayEnable, lcdPointerValid, ledPointerValid, lcdOk, ledOk;
	logic [5:0]  ramWriteAddr, pwmWave, auxPin, auxPinOe, lcdRamPointer, staticLevel, expLcd, expStatic;
	logic [7:0]  ramWriteData;
	logic [41:0] dutyValues, expDuty;
	logic [2:0]  ledChannelPointer, expLed;
	logic [13:0] expRam[$], gotRam[$];
	int          seed = 32'h5242d6ad, n_mismatch, compares, cycles, rdyMode, i, k;

	lpd_decoder lpd_decoder_inst (.clk, .reset, .byteValid, .byteIn, .byteReady, .configLoad, .configIn,
		.configOut, .ramReady, .ramWriteStrobe, .ramWriteAddr, .ramWriteData, .dutyValues, .pwmWave,
		.oscTick, .auxPin, .auxPinOe, .clockIoPinOut, .clockIoPinOe, .displayEnable, .lcdRamPointer,
		.lcdPointerValid, .ledChannelPointer, .ledPointerValid, .staticLevel);
	lpd_host_model lpd_host_model_inst (.clk, .reset, .slow, .byteReady, .byteValid, .byteIn);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ram may stall at random, or stall throughout to back up the fifo
	always @(posedge clk)
	begin
		pwmWave <= 6'($random(seed));
		oscTick <= 1'($random(seed));
		ramReady <= rdyMode == 0 || (rdyMode == 2 && 1'($random(seed)));
		if (ramWriteStrobe === 1'b1)
			gotRam.push_back({ramWriteAddr, ramWriteData});
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			wrap_up;
		end
	end

	function automatic logic [5:0] lim(input lpd_pkg::lpd_mux_type m);
		return m == lpd_pkg::LPD_MUX_8 ? 6'h27 : m == lpd_pkg::LPD_MUX_6 ? 6'h29 : 6'h2B;
	endfunction : lim

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk

	task automatic send(input logic d, input logic [1:0] s, input logic [7:0] v);
		lpd_host_model_inst.q.push_back({d, s, v});
		if (!d && v[7:3] == 5'h0C)
			expStatic[2:0] = v[2:0];
		else if (!d && v[7:3] == 5'h0D)
			expStatic[5:3] = v[2:0];
		else if (!d && v[7:3] == 5'h0E)
		begin
			ledOk = v[2:0] <= 3'h5;
			if (ledOk)
				expLed = v[2:0];
		end
		else if (!d && v[7:6] == 2'h2)
		begin
			lcdOk = v[5:0] <= lim(mux);
			if (lcdOk)
				expLcd = v[5:0];
		end
		else if (d && s == 2'h1 && lcdOk)
		begin
			expRam.push_back({expLcd, v});
			expLcd++;
			lcdOk = expLcd <= lim(mux);
		end
		else if (d && s == 2'h2 && ledOk)
			expDuty[expLed * 7 +: 7] = v[6:0];
	endtask : send

	task automatic cfg(input lpd_pkg::lpd_mux_type m, input lpd_pkg::lpd_aux_mode_type a, input logic on);
		configIn.muxMode <= m;
		configIn.displayOn <= on;
		foreach (configIn.auxOutputMode[j])
			configIn.auxOutputMode[j] <= a;
		configLoad <= 1'b1;
		mux = m;
		if (expLcd > lim(m))
			lcdOk = 1'b0;
		@(posedge clk);
		configLoad <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : cfg

	task automatic settle;
		for (k = 0; k < 400 && (lpd_host_model_inst.q.size() != 0 || byteValid); k++)
			@(posedge clk);
		rdyMode = 0;
		repeat (16) @(posedge clk);
		chk("static", expStatic, staticLevel);
		chk("lcd pointer", {lcdOk, expLcd}, {lcdPointerValid, lcdRamPointer});
		chk("pwm pointer", {ledOk, expLed}, {ledPointerValid, ledChannelPointer});
		chk("duty", expDuty, dutyValues);
		chk("ram count", expRam.size(), gotRam.size());
		while (expRam.size() != 0 && gotRam.size() != 0)
			chk("ram write", expRam.pop_front(), gotRam.pop_front());
		expRam = {};
		gotRam = {};
	endtask : settle

	task automatic do_reset;
		reset <= 1'b1;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		expStatic = '0;
		expLcd = '0;
		expLed = '0;
		expDuty = '0;
		lcdOk = 1'b1;
		ledOk = 1'b1;
		mux = lpd_pkg::LPD_MUX_8;
		chk("config", {24'h00_0000, 5'h0E, 4'h7}, configOut);
		chk("display off", 1'b0, displayEnable);
		chk("clock pin off", 2'b00, {clockIoPinOe, clockIoPinOut});
		settle;
	endtask : do_reset

	task automatic wrap_up;
		$display("mismatches %0d, comparisons %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	initial
	begin
		{reset, configLoad, ramReady, oscTick, slow, pwmWave} = 11'h400;
		configIn = {24'h00_0000, 5'h0E, 4'h7};
		{n_mismatch, compares, cycles, rdyMode} = '0;
		do_reset;
		for (i = 0; i < 8; i++)
		begin
			send(1'b0, 2'h0, {5'h0C, 3'($random(seed))});
			send(1'b0, 2'h0, {5'h0D, 3'($random(seed))});
		end
		cfg(lpd_pkg::LPD_MUX_8, lpd_pkg::LPD_AUX_STATIC, 1'b0);
		settle;
		chk("static pins", {expStatic, 6'h3F}, {auxPin, auxPinOe});
		cfg(lpd_pkg::LPD_MUX_8, lpd_pkg::LPD_AUX_OFF, 1'b0);
		chk("off pins", 12'h000, {auxPin, auxPinOe});
		for (i = 0; i < 3; i++)
		begin
			cfg(lpd_pkg::lpd_mux_type'(i), lpd_pkg::LPD_AUX_PWM, 1'b0);
			send(1'b0, 2'h0, {2'h2, lim(mux)});
			send(1'b1, 2'h1, 8'hA5);
			send(1'b1, 2'h1, 8'h5A);
			send(1'b0, 2'h0, {2'h2, 6'(lim(mux) + 6'h01)});
			send(1'b1, 2'h1, 8'h3C);
			send(1'b0, 2'h0, {3'h4, 5'($random(seed))});
			rdyMode = 2;
			slow = i[0];
			for (k = 0; k < 12; k++)
				send(1'b1, 2'($random(seed)), 8'($random(seed)));
			settle;
		end
		for (i = 0; i < 8; i++)
		begin
			send(1'b0, 2'h0, {5'h0E, 3'(i)});
			send(1'b1, 2'h2, 8'($random(seed)));
		end
		settle;
		rdyMode = 1;
		send(1'b0, 2'h0, 8'h80);
		for (i = 0; i < 12; i++)
			send(1'b1, 2'h1, 8'($random(seed)));
		repeat (30) @(posedge clk);
		chk("ready when full", 1'b0, byteReady);
		rdyMode = 2;
		send(1'b0, 2'h0, 8'h4B);
		settle;
		chk("pwm divider", 4'hB, configOut.ledFrameDividerCode);
		configIn.clockOutOn <= 1'b1;
		cfg(mux, lpd_pkg::LPD_AUX_OFF, 1'b1);
		chk("display", 1'b1, displayEnable);
		chk("clock pin on", 1'b1, clockIoPinOe);
		do_reset;
		wrap_up;
	end
endmodule : lpd_decoder_tb
